// ===== shared/asop_pkg.sv
package asop_pkg;
  localparam int          RES_W             = 16;
  localparam int          CLK_MHZ           = 250;
  // internal serial clock: four quarters per bit
  localparam int          SCLK_QUARTER_NS   = 8;
  localparam int          SCLK_QUARTER_CYC  = (SCLK_QUARTER_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0]  QUARTER_LAST      = 8'(SCLK_QUARTER_CYC - 1);
  localparam logic [4:0]  BITS_PER_WORD     = 5'h10;
  localparam logic [4:0]  LAST_BIT          = 5'h0F;
  localparam logic [15:0] RESULT_RST        = 16'h0000;
  localparam logic [15:0] MSB_MASK          = 16'h8000;
  localparam int          PAR_LO_BIT        = 5;
  localparam int          SHARED_W          = 4;
  localparam int          SERIAL_DATA_OUT_PIN         = 3;
  // synchroniser lanes
  localparam int          SYNC_W            = 9;
  localparam int          IDX_SCLK          = 0;
  localparam int          IDX_CS_N          = 1;
  localparam int          IDX_RD_N          = 2;
  localparam int          IDX_POL           = 3;
  localparam int          IDX_INV           = 4;
  localparam int          IDX_RDC           = 5;
  localparam int          IDX_SRC           = 6;
  localparam int          IDX_SER           = 7;
  localparam int          IDX_CODE          = 8;
  localparam logic [8:0]  SYNC_RST          = 9'h006;
  typedef enum logic {ST_IDLE, ST_SHIFT} asop_state_t;
endpackage : asop_pkg

// ===== shared/asop_pin_if.sv
`timescale 1ns/10ps
interface asop_pin_if;
  logic [asop_pkg::SYNC_W-1:0] raw;    // pins as they arrive
  logic [asop_pkg::SYNC_W-1:0] clean;  // after synchronising
  modport sync_side (input raw, output clean);
  modport core_side (output raw, input clean);
endinterface : asop_pin_if

// ===== rtl/asop_sync.sv
`timescale 1ns/10ps
module asop_sync (
  input  wire logic clk_sys,          // system clock
  input  wire logic rst,              // async reset, active high
  asop_pin_if.sync_side pins          // raw in, clean out
);
  logic [asop_pkg::SYNC_W-1:0] s1_q;
  logic [asop_pkg::SYNC_W-1:0] s2_q;
  logic [asop_pkg::SYNC_W-1:0] s3_q;
  logic [asop_pkg::SYNC_W-1:0] clean_q;
  logic [asop_pkg::SYNC_W-1:0] clean_d;

  // a lane only moves once the second and third stages agree
  assign clean_d    = (s2_q ~^ s3_q) & s3_q | (s2_q ^ s3_q) & clean_q;
  assign pins.clean = clean_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_q    <= asop_pkg::SYNC_RST;
      s2_q    <= asop_pkg::SYNC_RST;
      s3_q    <= asop_pkg::SYNC_RST;
      clean_q <= asop_pkg::SYNC_RST;
    end else begin
      s1_q    <= pins.raw;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      clean_q <= clean_d;
    end
  end
endmodule : asop_sync

// ===== rtl/asop_top.sv
`timescale 1ns/10ps
// How it works
// - parallel mode drives the four shared pins as result bits 5 to 8.
// - frame polarity select low gives active-high frame sync, high gives active-low.
// - serial clock invert flips clock sense in master and slave modes.
// - in slave mode the read-mode pin is the daisy-chain serial input.
// - chain input reaches serial output sixteen clock periods after read starts.
// - master, read-mode high: previous result shifts out during new conversion.
// - master, read-mode low: data shifts out only after conversion completes.
// - result held internally and shifted out most significant bit first.
// - serial word coding follows the output coding select input.
// - master output bit stable across both serial clock edges.
// - slave, invert low: update on rising edge, reader samples falling.
// - slave, invert high: update on falling edge, reader samples rising.
// - clock source low drives internal clock; high uses external clock gated by select.
// - master frame sync active for as long as serial data is valid.
// - coding select low inverts the msb for twos complement, high straight binary.
module asop_top (
  input  wire logic                          clk_sys,               // system clock
  input  wire logic                          rst,                   // async reset, active high
  input  wire logic                          port_type_select,      // high serial, low parallel
  input  wire logic                          clock_source_select,   // high external clock
  input  wire logic                          output_coding_select,  // high straight binary
  input  wire logic                          cs_n,                  // chip select, active low
  input  wire logic                          rd_n,                  // read strobe, active low
  input  wire logic                          conv_start,            // pulse, conversion begins
  input  wire logic                          conv_done,             // pulse, result ready
  input  wire logic [asop_pkg::RES_W-1:0]    conv_result,           // raw result with conv_done
  input  wire logic [asop_pkg::SHARED_W-1:0] shared_pin_i,          // shared pins, in
  output logic      [asop_pkg::SHARED_W-1:0] shared_pin_o,          // shared pins, out
  output logic      [asop_pkg::SHARED_W-1:0] shared_pin_oe,         // shared pins, drive enable
  input  wire logic                          sclk_i,                // serial clock pin, in
  output logic                               sclk_o,                // serial clock pin, out
  output logic                               sclk_oe,               // serial clock drive enable
  output logic                               frame_sync_o,          // frame sync pin
  output logic                               frame_sync_oe          // frame sync drive enable
);
  asop_pin_if pins ();

  // shared pin 0..2 carry polarity, invert and read-mode/chain in serial mode
  assign pins.raw[asop_pkg::IDX_SCLK] = sclk_i;
  assign pins.raw[asop_pkg::IDX_CS_N] = cs_n;
  assign pins.raw[asop_pkg::IDX_RD_N] = rd_n;
  assign pins.raw[asop_pkg::IDX_POL]  = shared_pin_i[0];
  assign pins.raw[asop_pkg::IDX_INV]  = shared_pin_i[1];
  assign pins.raw[asop_pkg::IDX_RDC]  = shared_pin_i[2];
  assign pins.raw[asop_pkg::IDX_SRC]  = clock_source_select;
  assign pins.raw[asop_pkg::IDX_SER]  = port_type_select;
  assign pins.raw[asop_pkg::IDX_CODE] = output_coding_select;

  asop_sync i_asop_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pins    (pins)
  );

  asop_pkg::asop_state_t        state_q;
  asop_pkg::asop_state_t        state_d;
  logic [asop_pkg::RES_W-1:0]   result_q;
  logic [asop_pkg::RES_W-1:0]   shreg_q;
  logic [asop_pkg::RES_W-1:0]   shreg_d;
  logic [4:0]                   cnt_q;
  logic [4:0]                   cnt_d;
  logic [7:0]                   qtim_q;
  logic [7:0]                   qtim_d;
  logic [1:0]                   ph_q;
  logic [1:0]                   ph_d;
  logic                         seff_q;
  logic                         bus_en_q;
  logic [asop_pkg::SHARED_W-1:0] pin_o_d;
  logic [asop_pkg::SHARED_W-1:0] pin_oe_d;
  logic                         sclk_o_d;
  logic                         sclk_oe_d;
  logic                         fs_d;
  logic                         fs_oe_d;

  wire logic       ser      = pins.clean[asop_pkg::IDX_SER];
  wire logic       ext      = pins.clean[asop_pkg::IDX_SRC];
  wire logic       inv      = pins.clean[asop_pkg::IDX_INV];
  wire logic       pol      = pins.clean[asop_pkg::IDX_POL];
  wire logic       rdc      = pins.clean[asop_pkg::IDX_RDC];
  wire logic       cs_lo    = ~pins.clean[asop_pkg::IDX_CS_N];
  wire logic       bus_en   = cs_lo & ~pins.clean[asop_pkg::IDX_RD_N];
  wire logic       master   = ser & ~ext;
  wire logic       slave    = ser & ext;
  wire logic       shifting = (state_q == asop_pkg::ST_SHIFT);
  // a read-after start must ship the word arriving with conv_done, not the held copy
  wire logic [15:0] fresh   = conv_done ? conv_result : result_q;
  wire logic [15:0] cmask   = pins.clean[asop_pkg::IDX_CODE] ? 16'h0000 : asop_pkg::MSB_MASK;
  // coding applied when the word leaves the holding register
  wire logic [15:0] coded   = fresh ^ cmask;
  // external clock seen through the invert select; update edge is its rising edge with invert low, its falling edge with invert high
  // the update lands about five system clocks after the pin edge, so a fast
  // link clock leaves the reader only the late part of the period to sample in
  wire logic       seff     = pins.clean[asop_pkg::IDX_SCLK] ^ inv;
  wire logic       upd_edge = slave & cs_lo & seff & ~seff_q;
  // a slave word loads when the bus enable rises; chain bits follow after sixteen
  wire logic       s_start  = slave & bus_en & ~bus_en_q;
  // read-mode pin picks read during or after conversion
  wire logic       m_start  = master & (rdc ? conv_start : conv_done);
  // a quarter rounds up to whole system clocks: the clock may run slow, never fast
  wire logic       q_end    = (qtim_q == asop_pkg::QUARTER_LAST);
  wire logic       bit_end  = q_end & (ph_q == 2'h3);
  wire logic       sclk_raw = shifting & master & (ph_q == 2'h1 | ph_q == 2'h2);
  wire logic       last_bit = (cnt_q == asop_pkg::LAST_BIT);
  wire logic       chain_on = (cnt_q == asop_pkg::BITS_PER_WORD);

  always_comb begin
    state_d = state_q;
    shreg_d = shreg_q;
    cnt_d   = cnt_q;
    qtim_d  = 8'h00;
    ph_d    = 2'h0;
    case (state_q)
      asop_pkg::ST_IDLE: begin
        if (m_start | s_start) begin
          state_d = asop_pkg::ST_SHIFT;
          shreg_d = coded;
          cnt_d   = 5'h00;
        end
      end
      asop_pkg::ST_SHIFT: begin
        if (master) begin
          // bit changes only at quarter 0, clock high in quarters 1-2
          qtim_d = q_end ? 8'h00 : qtim_q + 8'h01;
          ph_d   = q_end ? ph_q + 2'h1 : ph_q;
          if (bit_end) begin
            shreg_d = {shreg_q[14:0], 1'b0};
            cnt_d   = cnt_q + 5'h01;
            if (last_bit) begin
              state_d = asop_pkg::ST_IDLE;
            end
          end
        end else if (slave & bus_en) begin
          if (upd_edge) begin
            // chain bit enters at the bottom, out after sixteen periods
            shreg_d = {shreg_q[14:0], rdc};
            cnt_d   = chain_on ? cnt_q : cnt_q + 5'h01;
          end
        end else begin
          // dropping the bus enable mid-word ends the frame; unsent bits are lost
          state_d = asop_pkg::ST_IDLE;
        end
      end
      default: state_d = asop_pkg::ST_IDLE;
    endcase
  end

  // serial mode gives only the data pin back; the other three become inputs
  wire logic [asop_pkg::SHARED_W-1:0] ser_pins = {shreg_q[asop_pkg::RES_W-1], 3'h0};
  wire logic [asop_pkg::SHARED_W-1:0] par_pins = coded[asop_pkg::PAR_LO_BIT+asop_pkg::SHARED_W-1:asop_pkg::PAR_LO_BIT];
  wire logic [asop_pkg::SHARED_W-1:0] ser_oe   = {bus_en, 3'h0};
  wire logic [asop_pkg::SHARED_W-1:0] par_oe   = {asop_pkg::SHARED_W{bus_en}};

  assign pin_o_d   = ser ? ser_pins : par_pins;
  assign pin_oe_d  = ser ? ser_oe : par_oe;
  assign sclk_o_d  = sclk_raw ^ inv;
  assign sclk_oe_d = master;
  // frame sync and data both pass one output register, so they stay aligned
  assign fs_d      = (shifting & master) ^ pol;
  assign fs_oe_d   = master;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q  <= asop_pkg::ST_IDLE;
      shreg_q  <= asop_pkg::RESULT_RST;
      cnt_q    <= 5'h00;
    end else begin
      state_q  <= state_d;
      shreg_q  <= shreg_d;
      cnt_q    <= cnt_d;
    end
  end

  // edge history resets to the idle level so no false edge follows reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      qtim_q   <= 8'h00;
      ph_q     <= 2'h0;
      seff_q   <= 1'b0;
      bus_en_q <= 1'b0;
    end else begin
      qtim_q   <= qtim_d;
      ph_q     <= ph_d;
      seff_q   <= seff;
      bus_en_q <= bus_en;
    end
  end

  // holds the last finished result; read-during mode ships this old word
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      result_q <= asop_pkg::RESULT_RST;
    end else if (conv_done) begin
      result_q <= conv_result;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shared_pin_o  <= 4'h0;
      sclk_o        <= 1'b0;
      frame_sync_o  <= 1'b0;
    end else begin
      shared_pin_o  <= pin_o_d;
      sclk_o        <= sclk_o_d;
      frame_sync_o  <= fs_d;
    end
  end

  // enables reset low so nothing drives the pins until the modes have settled
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shared_pin_oe <= 4'h0;
      sclk_oe       <= 1'b0;
      frame_sync_oe <= 1'b0;
    end else begin
      shared_pin_oe <= pin_oe_d;
      sclk_oe       <= sclk_oe_d;
      frame_sync_oe <= fs_oe_d;
    end
  end
endmodule : asop_top

// ===== verif/asop_checker.sv
`timescale 1ns/10ps
module asop_checker (
  input wire logic                          clk_sys,             // system clock
  input wire logic                          rst,                 // async reset
  input wire logic                          port_type_select,    // serial mode
  input wire logic                          clock_source_select, // external clock
  input wire logic                          cs_n,                // chip select
  input wire logic                          rd_n,                // read strobe
  input wire logic [asop_pkg::SHARED_W-1:0] shared_pin_o,        // shared pins out
  input wire logic [asop_pkg::SHARED_W-1:0] shared_pin_oe,       // shared pins enable
  input wire logic                          sclk_o,              // internal clock
  input wire logic                          sclk_oe,             // clock enable
  input wire logic                          frame_sync_oe        // frame sync enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // pin levels pass a synchroniser, so a level must hold seven edges before it counts
  wire en = !cs_n && !rd_n;
  property p_par_oe; (!port_type_select && en)[*7] |-> shared_pin_oe == 4'hF; endproperty
  a_par_oe: assert property (p_par_oe) else $error("parallel pins not driven");
  property p_ser_oe; (port_type_select && en)[*7] |-> shared_pin_oe == 4'h8; endproperty
  a_ser_oe: assert property (p_ser_oe) else $error("serial pins wrongly driven");
  property p_off; cs_n[*7] |-> shared_pin_oe == 4'h0; endproperty
  a_off: assert property (p_off) else $error("pins driven while deselected");
  property p_mclk; (port_type_select && !clock_source_select)[*7] |-> sclk_oe; endproperty
  a_mclk: assert property (p_mclk) else $error("internal clock not driven");
  property p_sclk; clock_source_select[*7] |-> !sclk_oe && !frame_sync_oe; endproperty
  a_sclk: assert property (p_sclk) else $error("clock driven in slave mode");
  property p_fs_oe; (port_type_select && !clock_source_select)[*7] |-> frame_sync_oe; endproperty
  a_fs_oe: assert property (p_fs_oe) else $error("frame sync enable mismatch");
  property p_stable; sclk_oe && $changed(sclk_o) |-> $stable(shared_pin_o[3]); endproperty
  a_stable: assert property (p_stable) else $error("data moved on a clock edge");
  property p_shi; sclk_oe && $rose(sclk_o) |-> sclk_o[*4]; endproperty
  a_shi: assert property (p_shi) else $error("internal clock high too short");
  c_mclk: cover property (sclk_oe && $rose(sclk_o));
  c_par: cover property (shared_pin_oe == 4'hF);
  c_slv: cover property (port_type_select && clock_source_select && en);
endmodule : asop_checker
bind asop_top asop_checker i_asop_checker (.clk_sys, .rst, .port_type_select, .clock_source_select,
  .cs_n, .rd_n, .shared_pin_o, .shared_pin_oe, .sclk_o, .sclk_oe, .frame_sync_oe);

// ===== verif/asop_host_model.sv
`timescale 1ns/10ps
module asop_host_model (
  input  wire logic inv,   // clock sense
  input  wire logic sdo,   // serial data at pin
  output logic      sclk,  // serial clock
  output logic      cs_n,  // chip select
  output logic      rd_n,  // read strobe
  output logic [16:0] word // bits read, first in msb
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    rd_n = 1'b1;
    word = '0;
  end
  task automatic hold(input logic en);
    cs_n = !en;
    rd_n = !en;
  endtask : hold
  // clock stands still outside frames; data is taken just before the next updating
  // edge since the device synchroniser lands its update later than half a period
  task automatic frame(input int n);
    sclk = inv;
    #40;
    hold(1'b1);
    #80;
    repeat (n) begin
      word = {word[15:0], sdo};
      sclk = !inv;
      #16;
      sclk = inv;
      #16;
    end
    hold(1'b0);
    #80;
  endtask : frame
endmodule : asop_host_model

// ===== verif/tb_asop_top.sv
`timescale 1ns/10ps
module tb_asop_top;
  logic        clk_sys = 1'b0, rst, pts, css, ocs, start, done;
  logic [15:0] result;
  logic [3:0]  pin;
  wire  [3:0]  pin_o, pin_oe, pin_i;
  wire         sclk_o, sclk_oe, fs, fs_oe, h_sclk, cs_n, rd_n;
  wire  [16:0] h_word;
  int          error_cnt = 0, cmp_count = 0;
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & pin);
  wire         sclk_i = sclk_oe ? sclk_o : h_sclk;
  always #2 clk_sys = ~clk_sys;
  asop_top i_asop_top (.clk_sys(clk_sys), .rst(rst), .port_type_select(pts), .clock_source_select(css),
    .output_coding_select(ocs), .cs_n(cs_n), .rd_n(rd_n), .conv_start(start), .conv_done(done),
    .conv_result(result), .shared_pin_i(pin_i), .shared_pin_o(pin_o), .shared_pin_oe(pin_oe),
    .sclk_i(sclk_i), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .frame_sync_o(fs), .frame_sync_oe(fs_oe));
  asop_host_model i_asop_host_model (.inv(pin[1]), .sdo(pin_oe[3] ? pin_o[3] : ~pin_o[3]),
    .sclk(h_sclk), .cs_n(cs_n), .rd_n(rd_n), .word(h_word));
  task automatic end_of_test();
    if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic ticks(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : ticks
  task automatic pulse(input logic d);
    @(negedge clk_sys);
    if (d) done = 1'b1;
    else start = 1'b1;
    @(negedge clk_sys);
    done = 1'b0;
    start = 1'b0;
  endtask : pulse
  // samples each master bit late in its eight cycles, half a cycle before its second clock edge
  task automatic mread(input logic d, input logic [15:0] exp, input logic pol);
    logic [15:0] w, f;
    pulse(d);
    ticks(6);
    repeat (16) begin
      w = {w[14:0], pin_o[3]};
      f = {f[14:0], fs};
      ticks(8);
    end
    check("serial_data_out", w, exp);
    check("fsync", f, {16{!pol}});
    ticks(16);
    check("fs_idle", fs, pol);
  endtask : mread
  initial begin
    #40000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    pts = 1'b0;
    css = 1'b0;
    ocs = 1'b1;
    start = 1'b0;
    done = 1'b0;
    result = 16'h0000;
    pin = 4'h0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    ticks(6);
    i_asop_host_model.hold(1'b1);
    result = 16'h0160;
    pulse(1'b1);
    ticks(8);
    check("par_data", pin_o, 4'hB);
    check("par_oe", pin_oe, 4'hF);
    i_asop_host_model.hold(1'b0);
    ticks(8);
    check("off_oe", pin_oe, 4'h0);
    pts = 1'b1;
    pin = 4'h4;
    i_asop_host_model.hold(1'b1);
    result = 16'hA5C3;
    ticks(8);
    pulse(1'b1);
    result = 16'h1234;
    mread(1'b0, 16'hA5C3, 1'b0);
    check("ser_oe", pin_oe, 4'h8);
    ocs = 1'b0;
    pin = 4'h7;
    ticks(8);
    check("sclk_idle", sclk_o, 1'b1);
    mread(1'b0, 16'h25C3, 1'b1);
    ocs = 1'b1;
    pin = 4'h0;
    ticks(8);
    pulse(1'b0);
    ticks(20);
    check("no_start", fs, 1'b0);
    result = 16'h0F0F;
    mread(1'b1, 16'h0F0F, 1'b0);
    css = 1'b1;
    pin = 4'h4;
    i_asop_host_model.hold(1'b0);
    ticks(8);
    result = 16'h3C96;
    pulse(1'b1);
    i_asop_host_model.frame(17);
    check("chain_hi", h_word, {16'h3C96, 1'b1});
    ticks(1);
    pin = 4'h2;
    ticks(8);
    i_asop_host_model.frame(17);
    check("chain_lo", h_word, {16'h3C96, 1'b0});
    end_of_test();
  end
endmodule : tb_asop_top
